// ===== rlsp_pkg.sv
// Purpose: shared constants for the reset and link status pin block
// Assumes: 20 MHz clock, one clock domain
// Notes: long hold count is a top-level parameter default
package rlsp_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned RLSP_CLK_HZ = 20000000;
    localparam int unsigned RLSP_HOLD_MS = 50;
    localparam int unsigned RLSP_HOLD_CYC = RLSP_CLK_HZ / 1000 * RLSP_HOLD_MS;
    localparam int unsigned RLSP_RESET_MAX_CYC = 10;
    localparam int unsigned RLSP_CNT_W = 21;
    // ------------------------------------------------------------
    // polarity detection
    // ------------------------------------------------------------
    localparam logic [3:0] RLSP_REV_PULSES = 4'h7;
    localparam logic [3:0] RLSP_REV_PACKETS = 4'h3;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RLSP_START_RST = 1'b0;
    typedef enum logic [1:0] {RLSP_PIN_UNKNOWN, RLSP_PIN_OUT, RLSP_PIN_IN}
        rlsp_pin_role_t;
endpackage : rlsp_pkg

// ===== rlsp_stretch.sv
// Purpose: stretch an event pulse into a long hold level
// Assumes: event is synchronous to clk
// Notes: a new event restarts the hold
`timescale 1ns/10ps
`default_nettype none
module rlsp_stretch
    import rlsp_pkg::*;
#(
    parameter logic [RLSP_CNT_W-1:0] HOLD = RLSP_CNT_W'(RLSP_HOLD_CYC)
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic event_in,
    output logic active_q
);
    logic [RLSP_CNT_W-1:0] cnt_q;

    // ------------------------------------------------------------
    // hold counter
    // ------------------------------------------------------------
    // restart on every event so bursts keep the output high
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= '0;
            active_q <= 1'b0;
        end
        else if (event_in)
        begin
            cnt_q <= HOLD - RLSP_CNT_W'(1);
            active_q <= 1'b1;
        end
        else if (cnt_q != '0)
        begin
            cnt_q <= cnt_q - RLSP_CNT_W'(1);
        end
        else
        begin
            active_q <= 1'b0;
        end
    end

    property p_restart;
        @(posedge clk) disable iff (!reset_n)
        event_in |=> active_q && cnt_q == HOLD - RLSP_CNT_W'(1);
    endproperty
    a_restart: assert property (p_restart)
        else $error("hold not restarted by event");
endmodule : rlsp_stretch
`default_nettype wire

// ===== rlsp_polarity.sv
// Purpose: detect reversed receive polarity from consecutive observations
// Assumes: pulse and packet strobes are one-cycle, synchronous to clk
// Notes: once raised the flag stays until reset
`timescale 1ns/10ps
`default_nettype none
module rlsp_polarity
    import rlsp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_pulse,
    input wire logic pulse_inverted,
    input wire logic rx_packet,
    input wire logic packet_inverted,
    output logic reversed_q
);
    logic [3:0] pulse_run_q;
    logic [3:0] pkt_run_q;

    // ------------------------------------------------------------
    // consecutive link pulse run
    // ------------------------------------------------------------
    // a correct-polarity pulse breaks the run
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pulse_run_q <= 4'h0;
        else if (link_pulse)
            pulse_run_q <= pulse_inverted ? pulse_run_q + 4'h1 : 4'h0;
    end

    // consecutive packet run
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pkt_run_q <= 4'h0;
        else if (rx_packet)
            pkt_run_q <= packet_inverted ? pkt_run_q + 4'h1 : 4'h0;
    end

    // sticky flag; idle low
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            reversed_q <= 1'b0;
        else if (pulse_run_q >= RLSP_REV_PULSES ||
                 pkt_run_q >= RLSP_REV_PACKETS)
            reversed_q <= 1'b1;
    end

    property p_pkt_raise;
        @(posedge clk) disable iff (!reset_n)
        pkt_run_q == RLSP_REV_PACKETS |=> reversed_q;
    endproperty
    a_pkt_raise: assert property (p_pkt_raise)
        else $error("polarity flag missed after inverted packets");
endmodule : rlsp_polarity
`default_nettype wire

// ===== rlsp_top.sv
// Purpose: reset entry, packet hold-off and network status pins
// Assumes: all inputs synchronous to the 20 MHz clock
// Notes: link pin is open drain, enable low while driving
//
// How it works
// - a low reset_n forces every register to its reset state at once.
// - after reset no packet moves until the start bit is set.
// - reset completes at the first clock edge after reset_n is released, however long it was held.
// - the polarity output idles low and rises on inverted runs.
// - transmit activity output holds about 50 ms per transmission.
// - collision activity output holds about 50 ms per collision.
// - the link pin role is captured as reset is released.
// - an open or LED-loaded pin at release becomes an open-drain output.
// - in output role the pin is driven low while the link is good.
// - in output role the driver is off while the link is broken.
// - with the AUI path selected the pin is never driven low.
// - a pin held low at release is an input and disables link checks.
`timescale 1ns/10ps
`default_nettype none
module rlsp_top
    import rlsp_pkg::*;
#(
    parameter logic [RLSP_CNT_W-1:0] HOLD_CYCLES = RLSP_CNT_W'(RLSP_HOLD_CYC)
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start_command_bit,
    input wire logic interface_select_in,
    input wire logic factory_test_in,
    input wire logic tx_event,
    input wire logic collision_event,
    input wire logic link_intact,
    input wire logic link_pulse,
    input wire logic pulse_inverted,
    input wire logic rx_packet,
    input wire logic packet_inverted,
    input wire logic link_pin_in,
    output logic link_pin_out,
    output logic link_pin_oe_n,
    output logic polarity_reversed_out,
    output logic transmit_activity_out,
    output logic collision_activity_out,
    output logic regs_in_reset,
    output logic packets_enabled,
    output logic link_check_enabled
);
    logic released_q;
    logic started_q;
    rlsp_pin_role_t role_q;
    logic tx_q;
    logic col_q;
    logic rev_q;

    // shared by the pin driver and its check, so both read one decode
    function automatic logic is_out_role(input rlsp_pin_role_t r);
        return r == RLSP_PIN_OUT;
    endfunction : is_out_role

    // ------------------------------------------------------------
    // reset entry
    // ------------------------------------------------------------
    // registers held in reset until first edge after release
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            released_q <= 1'b0;
            regs_in_reset <= 1'b1;
        end
        else
        begin
            released_q <= 1'b1;
            regs_in_reset <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // packet hold-off
    // ------------------------------------------------------------
    // start is sticky; software cannot withdraw it except by reset
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            started_q <= RLSP_START_RST;
            packets_enabled <= 1'b0;
        end
        else
        begin
            if (start_command_bit)
                started_q <= 1'b1;
            packets_enabled <= started_q || start_command_bit;
        end
    end

    // ------------------------------------------------------------
    // link pin role capture
    // ------------------------------------------------------------
    // sampled at first clock after release; async reset takes constant
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            role_q <= RLSP_PIN_UNKNOWN;
        else if (!released_q)
            role_q <= link_pin_in ? RLSP_PIN_OUT : RLSP_PIN_IN;
    end

    // link check enable follows role
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            link_check_enabled <= 1'b1;
        else if (!released_q)
            link_check_enabled <= link_pin_in;
    end

    // ------------------------------------------------------------
    // open-drain drive
    // ------------------------------------------------------------
    // driver off until role is known so a strap is never fought
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link_pin_out <= 1'b0;
            link_pin_oe_n <= 1'b1;
        end
        else
        begin
            link_pin_out <= 1'b0;
            link_pin_oe_n <= !(is_out_role(role_q) && link_intact &&
                               !interface_select_in);
        end
    end

    // ------------------------------------------------------------
    // activity stretchers and polarity
    // ------------------------------------------------------------
    rlsp_stretch #(.HOLD(HOLD_CYCLES)) u_tx_stretch
    (
        .clk(clk),
        .reset_n(reset_n),
        .event_in(tx_event),
        .active_q(tx_q)
    );

    rlsp_stretch #(.HOLD(HOLD_CYCLES)) u_col_stretch
    (
        .clk(clk),
        .reset_n(reset_n),
        .event_in(collision_event),
        .active_q(col_q)
    );

    rlsp_polarity u_polarity
    (
        .clk(clk),
        .reset_n(reset_n),
        .link_pulse(link_pulse),
        .pulse_inverted(pulse_inverted),
        .rx_packet(rx_packet),
        .packet_inverted(packet_inverted),
        .reversed_q(rev_q)
    );

    // register outputs; factory test input has no effect here
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            transmit_activity_out <= 1'b0;
            collision_activity_out <= 1'b0;
            polarity_reversed_out <= 1'b0;
        end
        else
        begin
            transmit_activity_out <= tx_q;
            collision_activity_out <= col_q;
            polarity_reversed_out <= rev_q;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_tx_hit;
        tx_event ##1 1'b1;
    endsequence

    property p_tx_hold;
        @(posedge clk) disable iff (!reset_n)
        s_tx_hit |=> transmit_activity_out [*8];
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmit activity dropped early");

    property p_col_hold;
        @(posedge clk) disable iff (!reset_n)
        collision_event |=> ##1 collision_activity_out [*8];
    endproperty
    a_col_hold: assert property (p_col_hold)
        else $error("collision activity dropped early");

    property p_holdoff;
        @(posedge clk) disable iff (!reset_n)
        !started_q && !$past(start_command_bit) |-> !packets_enabled;
    endproperty
    a_holdoff: assert property (p_holdoff)
        else $error("packets enabled before start");

    property p_aui_quiet;
        @(posedge clk) disable iff (!reset_n)
        $past(interface_select_in) && released_q |-> link_pin_oe_n;
    endproperty
    a_aui_quiet: assert property (p_aui_quiet)
        else $error("link pin driven in aui mode");

    property p_drive_good;
        @(posedge clk) disable iff (!reset_n)
        is_out_role(role_q) && link_intact && !interface_select_in
        |=> !link_pin_oe_n && !link_pin_out;
    endproperty
    a_drive_good: assert property (p_drive_good)
        else $error("good link not shown");

    property p_release_bad;
        @(posedge clk) disable iff (!reset_n)
        !link_intact |=> link_pin_oe_n;
    endproperty
    a_release_bad: assert property (p_release_bad)
        else $error("broken link still driven");

    property p_input_role;
        @(posedge clk) disable iff (!reset_n)
        role_q == RLSP_PIN_IN |-> !link_check_enabled && link_pin_oe_n;
    endproperty
    a_input_role: assert property (p_input_role)
        else $error("input role misbehaves");

    property p_reset_done;
        @(posedge clk) disable iff (!reset_n)
        released_q |-> !regs_in_reset;
    endproperty
    a_reset_done: assert property (p_reset_done)
        else $error("reset not completed in time");

    // two low samples, so the first edge of the run is not judged
    sequence s_held_low;
        !reset_n ##1 !reset_n;
    endsequence

    property p_reset_state;
        @(posedge clk)
        s_held_low |-> regs_in_reset && !packets_enabled && link_pin_oe_n &&
            !transmit_activity_out && !collision_activity_out &&
            !polarity_reversed_out && link_check_enabled;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("outputs not in reset state while reset is low");

    property p_reset_exit;
        @(posedge clk) disable iff (!reset_n)
        !released_q |=> !regs_in_reset;
    endproperty
    a_reset_exit: assert property (p_reset_exit)
        else $error("registers still held after release");

    // strap level seen at the first edge after release
    sequence s_strap_high;
        !released_q && link_pin_in;
    endsequence

    sequence s_strap_low;
        !released_q && !link_pin_in;
    endsequence

    property p_role_out;
        @(posedge clk) disable iff (!reset_n)
        s_strap_high |=> role_q == RLSP_PIN_OUT && link_check_enabled;
    endproperty
    a_role_out: assert property (p_role_out)
        else $error("open pin not taken as output");

    property p_role_in;
        @(posedge clk) disable iff (!reset_n)
        s_strap_low |=> role_q == RLSP_PIN_IN && !link_check_enabled;
    endproperty
    a_role_in: assert property (p_role_in)
        else $error("grounded pin not taken as input");

    property p_role_fixed;
        @(posedge clk) disable iff (!reset_n)
        released_q |=> $stable(role_q) && $stable(link_check_enabled);
    endproperty
    a_role_fixed: assert property (p_role_fixed)
        else $error("pin role changed outside reset release");

    property p_start_seen;
        @(posedge clk) disable iff (!reset_n)
        start_command_bit |=> packets_enabled [*2];
    endproperty
    a_start_seen: assert property (p_start_seen)
        else $error("start not followed by packet enable");

    property p_rev_sticky;
        @(posedge clk) disable iff (!reset_n)
        polarity_reversed_out |=> polarity_reversed_out;
    endproperty
    a_rev_sticky: assert property (p_rev_sticky)
        else $error("polarity flag dropped before reset");
endmodule : rlsp_top
`default_nettype wire

// ===== rlsp_board.sv
// Purpose: board side of the link pin: pull-up, LED or tie to ground
// Assumes: pin enable is low while the block pulls the pin
// Notes: an open or LED-loaded pin rests high through the pull-up
`timescale 1ns/10ps
`default_nettype none
module rlsp_board
(
    input wire logic link_pin_out,
    input wire logic link_pin_oe_n,
    input wire logic tie_low,
    output logic link_pin_in
);
    // wired level; a tie to ground beats the block's driver
    assign link_pin_in = tie_low ? 1'b0 :
        (link_pin_oe_n ? 1'b1 : link_pin_out);
endmodule : rlsp_board
`default_nettype wire

// ===== test_reset_and_link_status_pins.sv
// Purpose: self-checking bench for the reset and link status pins
// Assumes: inputs change at the falling edge, hold shortened to 20
// Notes: each scenario is one task that judges its own outcome
`timescale 1ns/10ps
`default_nettype none
module test_reset_and_link_status_pins;
    import rlsp_pkg::*;
    localparam logic [RLSP_CNT_W-1:0] HOLD = 21'h000014;
    logic clk, reset_n, start, sel, ftest, tx, col, intact;
    logic lp, lpi, rx, rxi, tie, pin_in, pin_out, oe_n;
    logic rev, txa, cola, rir, pke, lce;
    int err_count, n_compared, cyc;

    rlsp_top #(.HOLD_CYCLES(HOLD)) u_rlsp_top (.clk(clk),
        .reset_n(reset_n), .start_command_bit(start),
        .interface_select_in(sel), .factory_test_in(ftest),
        .tx_event(tx), .collision_event(col), .link_intact(intact),
        .link_pulse(lp), .pulse_inverted(lpi), .rx_packet(rx),
        .packet_inverted(rxi), .link_pin_in(pin_in),
        .link_pin_out(pin_out), .link_pin_oe_n(oe_n),
        .polarity_reversed_out(rev), .transmit_activity_out(txa),
        .collision_activity_out(cola), .regs_in_reset(rir),
        .packets_enabled(pke), .link_check_enabled(lce));
    rlsp_board u_rlsp_board (.link_pin_out(pin_out),
        .link_pin_oe_n(oe_n), .tie_low(tie), .link_pin_in(pin_in));

    // clock and a cycle ceiling so a hang still reaches the verdict
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic g, input logic e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic nc(input int n);
        repeat (n) @(negedge clk);
    endtask : nc
    // one-cycle strobe then a quiet cycle, so no double drive
    task automatic ev(input int k);
        {rx, lp, col, tx} = 4'h1 << k;
        nc(1);
        {rx, lp, col, tx} = 4'h0;
        nc(1);
    endtask : ev
    task automatic do_reset(input logic t);
        tie = t;
        reset_n = 1'b0;
        nc(6);
        reset_n = 1'b1;
        nc(2);
    endtask : do_reset
    function automatic logic act(input int k);
        return (k == 0) ? txa : cola;
    endfunction : act

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        start = 1'b1;
        ev(0);
        start = 1'b0;
        reset_n = 1'b0;
        #1;
        chk(txa, 1'b0);
        chk(rir, 1'b1);
        chk(pke, 1'b0);
        nc(10);
        chk(rir, 1'b1);
        reset_n = 1'b1;
        nc(2);
        chk(rir, 1'b0);
        nc(5);
        chk(pke, 1'b0);
        start = 1'b1;
        nc(2);
        start = 1'b0;
        nc(1);
        chk(pke, 1'b1);
        $display("test reset done");
    endtask : t_reset
    // a retrigger late in the hold must keep the output up
    task automatic t_act(input int k);
        ev(k);
        nc(1);
        chk(act(k), 1'b1);
        nc(8);
        ev(k);
        nc(int'(HOLD) - 4);
        chk(act(k), 1'b1);
        nc(10);
        chk(act(k), 1'b0);
        $display("test activity %0d done", k);
    endtask : t_act
    task automatic t_polarity;
        lpi = 1'b1;
        repeat (6) ev(2);
        lpi = 1'b0;
        ev(2);
        lpi = 1'b1;
        repeat (6) ev(2);
        nc(3);
        chk(rev, 1'b0);
        ev(2);
        nc(3);
        chk(rev, 1'b1);
        lpi = 1'b0;
        do_reset(1'b0);
        chk(rev, 1'b0);
        rxi = 1'b1;
        repeat (2) ev(3);
        nc(3);
        chk(rev, 1'b0);
        ev(3);
        nc(3);
        chk(rev, 1'b1);
        rxi = 1'b0;
        $display("test polarity done");
    endtask : t_polarity
    task automatic t_link;
        intact = 1'b1;
        do_reset(1'b0);
        nc(3);
        chk(oe_n, 1'b0);
        chk(pin_out, 1'b0);
        chk(lce, 1'b1);
        intact = 1'b0;
        nc(3);
        chk(oe_n, 1'b1);
        intact = 1'b1;
        sel = 1'b1;
        nc(3);
        chk(pin_in, 1'b1);
        sel = 1'b0;
        do_reset(1'b1);
        nc(3);
        chk(lce, 1'b0);
        tie = 1'b0;
        nc(3);
        chk(oe_n, 1'b1);
        chk(lce, 1'b0);
        $display("test link pin done");
    endtask : t_link

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    // main sequence; test input held low throughout
    initial
    begin
        {clk, start, sel, tx, col, intact, lp, lpi, rx, rxi} = 10'h000;
        ftest = 1'b0;
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        do_reset(1'b0);
        t_reset();
        t_act(0);
        t_act(1);
        t_polarity();
        t_link();
        finish_test();
    end
endmodule : test_reset_and_link_status_pins
`default_nettype wire
